/* File: hw/frp_defines.svh */
`ifndef FRP_DEFINES_SVH
`define FRP_DEFINES_SVH
`define FRP_ADDR_W        32
`define FRP_SEL_HI        15
`define FRP_SEL_LO        14
`define FRP_ROM_BASE      32'hBFC0_0000
`define FRP_ROM_MASK      32'hFFF8_0000
`define FRP_BLK_HI        18
`define FRP_BLK_LO        17
`define FRP_CYC_ID        3'h4
`define FRP_CYC_PB        3'h7
`define FRP_ID_MAKER      2'h0
`define FRP_ID_PART       2'h1
`define FRP_ID_RSVD       2'h2
`define FRP_ID_MACRO      2'h3
`define FRP_MASKED_DATA   32'h0000_0000
`define FRP_REG_FLASH_ST  4'h0
`define FRP_REG_ROM_A     4'h4
`define FRP_REG_ROM_B     4'h8
`define FRP_REG_DEBUG     4'hC
`define FRP_ROM_A_RST     1'h0
`define FRP_ROM_B_RST     8'h00
`define FRP_DEBUG_RST     1'h1
`define FRP_PROT_RST      4'h0
`define FRP_ALL_PROT      4'hF
`define FRP_BIT_RSECON    0
`define FRP_BIT_DBGOFF    0
`define FRP_MIN_GAP_CYC   15
`endif

/* File: hw/frp_pkg.sv */
package frp_pkg;
   typedef enum logic [1:0] {FRP_OP_NONE, FRP_OP_PB_PROG, FRP_OP_PB_ERASE,
                             FRP_OP_ID_READ} frp_op_e;
   typedef enum {FRP_IDLE, FRP_WIPE, FRP_CLEAR} frp_st_e;
endpackage : frp_pkg

/* File: hw/frp_protect.sv */
// Overview of operation
// - Seventh cycle address bits pick block.
// - Protect erase clears pairs by bit 15.
// - ID cycle bits 15:14 pick code.
// - Protected blocks refuse program and erase.
// - Clearing bit unprotects; bits readable.
// - Releasing full protect wipes flash first.
// - Mask variant keeps full protect always.
// - ROM and debug protect need full protect.
// - ROM protect equals enable and full protect.
// - Block ROM data from non-ROM code.
// - DMA config stores refused with NMI.
// - ROM protect registers only from ROM.
// - Non-writer, unprotect and ROM-address flash commands refused under ROM protect.
// - Permitted accesses still pass through.
// - Debug port ROM data access blocked.
// - Debug protect disables external probe.
// - Debug disable bit resets to one.
// - Flash variant needs all four protected.
// - Debug bit reachable only from ROM under ROM protect.
// - Patched fetches count as non-ROM.
`timescale 1ns/1ps
`include "frp_defines.svh"
module frp_protect
   import frp_pkg::*;
#(
   parameter bit          MASK_VARIANT = 1'b0,
   parameter logic [7:0]  ID_MAKER     = 8'h11,  // Arbitrary value.
   parameter logic [7:0]  ID_PART      = 8'h22,  // Arbitrary value.
   parameter logic [7:0]  ID_MACRO     = 8'h33,  // Arbitrary value.
   parameter int          WIPE_CYCLES  = 16
)
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rstn,
   // Register port
   input  wire logic [3:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic                    reg_from_rom,
   output logic      [31:0]             reg_rdata,
   // Data access from CPU, debug port or DMA
   input  wire logic                    acc_valid,
   input  wire logic                    acc_write,
   input  wire logic [31:0]             acc_addr,
   input  wire logic [31:0]             acc_rdata_in,
   input  wire logic [31:0]             fetch_pc,
   input  wire logic                    fetch_patched,
   input  wire logic                    fetch_boot_rom,
   input  wire logic                    fetch_writer,
   input  wire logic                    acc_debug,
   input  wire logic                    acc_dma,
   input  wire logic                    acc_dma_cfg,
   output logic                         acc_allow,
   output logic      [31:0]             acc_rdata,
   output logic                         bus_error_nmi,
   // Flash command cycles
   input  wire logic                    cmd_valid,
   input  wire logic [2:0]              cmd_cycle,
   input  wire frp_op_e                 cmd_op,
   input  wire logic [31:0]             cmd_addr,
   input  wire logic                    cmd_writer_mode,
   input  wire logic                    cmd_is_unprotect,
   input  wire logic                    cmd_is_prog_erase,
   input  wire logic                    word_load,
   output logic                         cmd_refused,
   output logic      [7:0]              id_code,
   output logic                         id_valid,
   // Flash wipe handshake and status
   input  wire logic                    wipe_done,
   output logic                         wipe_req,
   output logic      [3:0]              block_protect_bits,
   output logic                         rom_protect_on,
   output logic                         debug_probe_disable
);
   // Refuses a wipe length that the handshake cannot serve.
   if (WIPE_CYCLES < 1)
   begin : g_bad_wipe
      $error("WIPE_CYCLES must be at least one");
   end

   typedef struct packed {
      logic [3:0]  prot;
      logic        rom_a;
      logic [7:0]  rom_b;
      logic        dbg_off;
      frp_st_e     st;
      logic [1:0]  id_sel;
      logic        id_arm;
      logic [31:0] rdata;
      logic        allow;
      logic [31:0] adata;
      logic        nmi;
      logic        refused;
      logic [7:0]  idc;
      logic        idv;
      logic        wreq;
      logic        dbg_pin;
      logic        rom_on;
   } frp_state_s;

   frp_state_s s_q;
   frp_state_s s_d;

   function automatic logic in_rom(input logic [31:0] a);
      in_rom = ((a & `FRP_ROM_MASK) == `FRP_ROM_BASE);
   endfunction : in_rom

   function automatic logic [1:0] sel_bits(input logic [31:0] a);
      sel_bits = a[`FRP_SEL_HI:`FRP_SEL_LO];
   endfunction : sel_bits

   logic full_prot;
   logic rom_prot;
   logic rom_fetch;
   logic [1:0] blk;

   always_comb
   begin
      full_prot = MASK_VARIANT || (s_q.prot == `FRP_ALL_PROT);
      rom_prot  = s_q.rom_a && full_prot;
      rom_fetch = in_rom(fetch_pc) && !fetch_patched;
      blk       = cmd_addr[`FRP_BLK_HI:`FRP_BLK_LO];

      s_d         = s_q;
      s_d.rdata   = 32'h0000_0000;
      s_d.nmi     = 1'b0;
      s_d.refused = 1'b0;
      s_d.idv     = 1'b0;
      s_d.allow   = 1'b0;
      s_d.adata   = `FRP_MASKED_DATA;

      // Register reads; ROM and debug protect registers hidden from non-ROM code under ROM protect.
      if (reg_rd)
      begin
         case (reg_addr)
            `FRP_REG_FLASH_ST: s_d.rdata = {28'h0, s_q.prot};
            `FRP_REG_ROM_A:
               if (!rom_prot || reg_from_rom)
                  s_d.rdata = {31'h0, s_q.rom_a};
            `FRP_REG_ROM_B:
               if (!rom_prot || reg_from_rom)
                  s_d.rdata = {24'h0, s_q.rom_b};
            `FRP_REG_DEBUG:
               if (!rom_prot || reg_from_rom)
                  s_d.rdata = {31'h0, s_q.dbg_off};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      if (reg_wr && (!rom_prot || reg_from_rom))
      begin
         case (reg_addr)
            `FRP_REG_ROM_A: s_d.rom_a = reg_wdata[`FRP_BIT_RSECON];
            `FRP_REG_ROM_B: s_d.rom_b = reg_wdata[7:0];
            `FRP_REG_DEBUG:
               s_d.dbg_off = reg_wdata[`FRP_BIT_DBGOFF];
            default: ;
         endcase
      end

      // Data access filter.
      if (acc_valid)
      begin
         s_d.allow = 1'b1;
         if (rom_prot)
         begin
            if (acc_dma_cfg && acc_write)
            begin
               s_d.allow = 1'b0;
               s_d.nmi   = 1'b1;
            end
            else if (in_rom(acc_addr) && !acc_dma)
            begin
               if (acc_debug)
                  s_d.allow = 1'b0;
               else if (!rom_fetch || fetch_boot_rom || fetch_writer ||
                        acc_write)
                  s_d.allow = 1'b0;
            end
         end
         if (s_d.allow && !acc_write)
            s_d.adata = acc_rdata_in;
         else
            s_d.adata = `FRP_MASKED_DATA;
      end

      // Flash command handling.
      if (cmd_valid)
      begin
         if (rom_prot && (!cmd_writer_mode || cmd_is_unprotect ||
                          in_rom(cmd_addr)))
            s_d.refused = 1'b1;
         else if (cmd_is_prog_erase && s_q.prot[blk])
            s_d.refused = 1'b1;
         else if (s_q.st == FRP_IDLE)
         begin
            case (cmd_op)
               FRP_OP_PB_PROG:
                  if (cmd_cycle == `FRP_CYC_PB)
                     s_d.prot[sel_bits(cmd_addr)] = 1'b1;
               FRP_OP_PB_ERASE:
                  if (cmd_cycle == `FRP_CYC_PB && !MASK_VARIANT)
                  begin
                     if (full_prot)
                     begin
                        s_d.st   = FRP_WIPE;
                        s_d.wreq = 1'b1;
                     end
                     else if (cmd_addr[`FRP_SEL_HI])
                        s_d.prot[3:2] = 2'b00;
                     else
                        s_d.prot[1:0] = 2'b00;
                  end
               FRP_OP_ID_READ:
                  if (cmd_cycle == `FRP_CYC_ID)
                  begin
                     s_d.id_sel = sel_bits(cmd_addr);
                     s_d.id_arm = 1'b1;
                  end
               default: ;
            endcase
         end
      end

      // Identification readout on the following word load.
      if (word_load && s_q.id_arm)
      begin
         s_d.id_arm = 1'b0;
         s_d.idv    = 1'b1;
         case (s_q.id_sel)
            `FRP_ID_MAKER: s_d.idc = ID_MAKER;
            `FRP_ID_PART:  s_d.idc = ID_PART;
            `FRP_ID_MACRO: s_d.idc = ID_MACRO;
            default:       s_d.idc = 8'h00;
         endcase
      end

      // Whole-flash wipe precedes release of full protect.
      case (s_q.st)
         FRP_IDLE: ;
         FRP_WIPE:
            if (wipe_done)
            begin
               s_d.wreq = 1'b0;
               s_d.st   = FRP_CLEAR;
            end
         FRP_CLEAR:
         begin
            s_d.prot = `FRP_PROT_RST;
            s_d.st   = FRP_IDLE;
         end
         default: s_d.st = FRP_IDLE;
      endcase

      s_d.rom_on  = s_d.rom_a &&
                    (MASK_VARIANT || s_d.prot == `FRP_ALL_PROT);
      // Flash variant enters debug protect only with all blocks protected.
      s_d.dbg_pin = s_d.dbg_off &&
                    (MASK_VARIANT || s_d.prot == `FRP_ALL_PROT);
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q         <= '0;
         s_q.prot    <= `FRP_PROT_RST;
         s_q.rom_a   <= `FRP_ROM_A_RST;
         s_q.rom_b   <= `FRP_ROM_B_RST;
         s_q.dbg_off <= `FRP_DEBUG_RST;
         s_q.dbg_pin <= MASK_VARIANT;
         s_q.st      <= FRP_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata           = s_q.rdata;
   assign acc_allow           = s_q.allow;
   assign acc_rdata           = s_q.adata;
   assign bus_error_nmi       = s_q.nmi;
   assign cmd_refused         = s_q.refused;
   assign id_code             = s_q.idc;
   assign id_valid            = s_q.idv;
   assign wipe_req            = s_q.wreq;
   assign block_protect_bits  = s_q.prot;
   assign rom_protect_on      = s_q.rom_on;
   assign debug_probe_disable = s_q.dbg_pin;
endmodule : frp_protect

/* File: sim/frp_protect_chk.sv */
`timescale 1ns/1ps
`include "frp_defines.svh"
module frp_protect_chk
   import frp_pkg::*;
#(
   parameter bit MASK_VARIANT = 1'b0
)
(
   // Clock and reset
   input wire logic        sys_clk, rstn,
   // Data access
   input wire logic        acc_valid, acc_write, acc_debug, acc_dma_cfg,
   input wire logic        fetch_patched, fetch_boot_rom, fetch_writer,
   input wire logic [31:0] fetch_pc, acc_rdata_in, acc_rdata,
   input wire logic        acc_allow, bus_error_nmi,
   // Commands and status
   input wire logic        cmd_valid, cmd_is_prog_erase, word_load,
   input wire logic [31:0] cmd_addr,
   input wire logic        cmd_refused, id_valid, wipe_done, wipe_req,
   input wire logic [3:0]  block_protect_bits,
   input wire logic        rom_protect_on, debug_probe_disable
);
   wire pc_rom  = (fetch_pc & `FRP_ROM_MASK) == `FRP_ROM_BASE;
   wire cmd_rom = (cmd_addr & `FRP_ROM_MASK) == `FRP_ROM_BASE;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   AST_DBG_ALL:
      assert property (!MASK_VARIANT && debug_probe_disable
         |-> block_protect_bits == `FRP_ALL_PROT)
      else $error("probe disabled without full protect");
   AST_ROM_ALL:
      assert property (!MASK_VARIANT && rom_protect_on
         |-> block_protect_bits == `FRP_ALL_PROT)
      else $error("rom protect without full protect");
   AST_NMI:
      assert property (bus_error_nmi |-> $past(acc_valid && acc_write
         && acc_dma_cfg && rom_protect_on))
      else $error("bus error without refused dma store");
   AST_MASKED:
      assert property (!acc_allow |-> acc_rdata == `FRP_MASKED_DATA)
      else $error("blocked access leaks data");
   AST_ROM_LOAD:
      assert property (acc_valid && !acc_write && !acc_debug && pc_rom
         && !fetch_patched && !fetch_boot_rom && !fetch_writer
         |=> acc_allow && acc_rdata == $past(acc_rdata_in))
      else $error("rom code load refused");
   AST_CMD_ROM:
      assert property (cmd_valid && rom_protect_on && !wipe_req && cmd_rom
         |=> cmd_refused)
      else $error("command accepted under rom protect");
   AST_PROT:
      assert property (cmd_valid && cmd_is_prog_erase && !wipe_req
         && block_protect_bits[cmd_addr[18:17]] |=> cmd_refused)
      else $error("protected block accepted program or erase");
   AST_HOLD:
      assert property (wipe_req |-> block_protect_bits == `FRP_ALL_PROT)
      else $error("protect cleared before wipe finished");
   AST_WIPE_CLR:
      assert property (wipe_req && wipe_done
         |-> ##[1:2] block_protect_bits == 4'h0)
      else $error("protect not cleared after wipe");
   AST_ID:
      assert property (id_valid |-> $past(word_load))
      else $error("id code without word load");
endmodule : frp_protect_chk

bind frp_protect frp_protect_chk #(.MASK_VARIANT(MASK_VARIANT)) i_chk (.*);

/* File: sim/frp_flash_model.sv */
`timescale 1ns/1ps
module frp_flash_model #(
   parameter int DELAY = 8
)
(
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic wipe_req,
   output logic      wipe_done
);
   int cnt_q;
   // Answers a whole-array wipe DELAY+1 cycles after wipe_req rises, with a one-cycle pulse.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_q     <= 0;
         wipe_done <= 1'b0;
      end
      else
      begin
         wipe_done <= wipe_req && cnt_q == DELAY;
         cnt_q     <= (wipe_req && cnt_q < DELAY) ? cnt_q + 1 : 0;
      end
   end
endmodule : frp_flash_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import frp_pkg::*;
;
   localparam logic [31:0] ROM = 32'hBFC0_0100, RAM = 32'h8000_0000;
   localparam logic [31:0] RD = 32'hBFC1_0000, XD = 32'hA000_0000;
   localparam logic [31:0] BASE = 32'hBFC0_0000, RAW = 32'h1234_5678;
   logic sys_clk, rstn, reg_wr, reg_rd, reg_from_rom, acc_valid, acc_write;
   logic fetch_patched, fetch_boot_rom, fetch_writer, acc_debug, acc_dma;
   logic acc_dma_cfg, cmd_valid, cmd_writer_mode, cmd_is_unprotect;
   logic cmd_is_prog_erase, word_load, wipe_done, acc_allow, bus_error_nmi;
   logic cmd_refused, id_valid, wipe_req, rom_protect_on, debug_probe_disable;
   logic [3:0]  reg_addr, block_protect_bits;
   logic [31:0] reg_wdata, reg_rdata, acc_addr, acc_rdata_in, fetch_pc;
   logic [31:0] acc_rdata, cmd_addr;
   logic [2:0]  cmd_cycle;
   logic [7:0]  id_code;
   frp_op_e     cmd_op;
   int          fail_count = 0, cmp_count = 0, cyc = 0, i;
   logic [7:0]  ids [4] = '{8'h11, 8'h22, 8'h00, 8'h33};

   frp_protect i_dut (.*);
   frp_flash_model #(.DELAY(40)) i_flash (.*);

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fail_count++;
         report_and_stop;
      end
   end

   task chk(input string n, input logic [31:0] got, e);
      cmp_count++;
      if (got !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, got);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic rom, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_from_rom <= rom;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask : wr

   task rd(input logic [3:0] a, input logic rom, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_from_rom <= rom;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk("reg_rdata", reg_rdata, e);
   endtask : rd

   task cmd(input logic [2:0] cy, input frp_op_e op, input logic [31:0] a,
            input logic pe, wl, er);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_cycle <= cy;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_is_prog_erase <= pe;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      word_load <= wl;
      @(negedge sys_clk);
      chk("refused", cmd_refused, er);
      @(posedge sys_clk);
      word_load <= 1'b0;
      @(negedge sys_clk);
      if (wl)
      begin
         chk("id_valid", id_valid, 1);
         chk("id_code", id_code, ids[a[15:14]]);
      end
      repeat (15) @(negedge sys_clk);
   endtask : cmd

   task acc(input logic [31:0] pc, a, input logic [5:0] f, input logic ea, en);
      @(posedge sys_clk);
      {acc_write, fetch_patched, acc_debug, acc_dma, acc_dma_cfg,
       fetch_boot_rom} <= f;
      fetch_pc <= pc;
      acc_addr <= a;
      acc_valid <= 1'b1;
      @(posedge sys_clk);
      acc_valid <= 1'b0;
      @(negedge sys_clk);
      chk("allow", acc_allow, ea);
      chk("rdata", acc_rdata, (ea && !f[5]) ? RAW : 32'h0);
      chk("nmi", bus_error_nmi, en);
   endtask : acc

   initial
   begin
      {rstn, reg_wr, reg_rd, reg_from_rom, acc_valid, acc_write, fetch_patched,
       fetch_boot_rom, fetch_writer, acc_debug, acc_dma, acc_dma_cfg, cmd_valid,
       cmd_is_unprotect, cmd_is_prog_erase, word_load} = '0;
      {reg_addr, reg_wdata, acc_addr, fetch_pc, cmd_cycle, cmd_addr} = '0;
      cmd_writer_mode = 1'b1;
      acc_rdata_in = RAW;
      cmd_op = FRP_OP_NONE;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      chk("probe", debug_probe_disable, 0);
      rd(4'hC, 1, 1);
      rd(4'h2, 1, 0);
      for (i = 0; i < 4; i++)
      begin
         cmd(3'h7, FRP_OP_PB_PROG, BASE | (i << 14), 0, 0, 0);
         chk("bits", block_protect_bits, (1 << (i + 1)) - 1);
      end
      chk("probe", debug_probe_disable, 1);
      cmd(3'h6, FRP_OP_NONE, 32'hBFC3_0004, 1, 0, 1);
      wr(4'h4, 1, 1);
      chk("rom", rom_protect_on, 1);
      acc(RAM, RD, 6'h00, 0, 0);
      acc(ROM, RD, 6'h00, 1, 0);
      acc(ROM, RD, 6'h10, 0, 0);
      acc(ROM, RD, 6'h08, 0, 0);
      acc(ROM, RD, 6'h01, 0, 0);
      acc(RAM, XD, 6'h00, 1, 0);
      acc(RAM, RD, 6'h04, 1, 0);
      acc(RAM, XD, 6'h22, 0, 1);
      acc(RAM, RD, 6'h20, 0, 0);
      fetch_writer <= 1'b1;
      acc(ROM, RD, 6'h00, 0, 0);
      fetch_writer <= 1'b0;
      wr(4'h8, 1, 32'hA5);
      rd(4'h8, 1, 32'hA5);
      rd(4'h8, 0, 0);
      cmd_writer_mode <= 1'b0;
      cmd(3'h7, FRP_OP_PB_PROG, RAM, 0, 0, 1);
      cmd_writer_mode <= 1'b1;
      cmd_is_unprotect <= 1'b1;
      cmd(3'h7, FRP_OP_PB_ERASE, RAM, 0, 0, 1);
      cmd_is_unprotect <= 1'b0;
      chk("bits", block_protect_bits, 4'hF);
      rd(4'hC, 0, 0);
      rd(4'h4, 0, 0);
      wr(4'hC, 0, 0);
      wr(4'h4, 0, 0);
      chk("probe", debug_probe_disable, 1);
      chk("rom", rom_protect_on, 1);
      cmd(3'h4, FRP_OP_ID_READ, BASE, 0, 0, 1);
      wr(4'hC, 1, 0);
      chk("probe", debug_probe_disable, 0);
      wr(4'h4, 1, 0);
      chk("rom", rom_protect_on, 0);
      for (i = 0; i < 4; i++)
         cmd(3'h4, FRP_OP_ID_READ, BASE | (i << 14), 0, 1, 0);
      cmd(3'h7, FRP_OP_PB_ERASE, BASE, 0, 0, 0);
      chk("wipe", wipe_req, 1);
      chk("bits", block_protect_bits, 4'hF);
      for (i = 0; i < 200 && block_protect_bits !== 4'h0; i++)
         @(negedge sys_clk);
      chk("bits", block_protect_bits, 0);
      for (i = 0; i < 3; i++)
         cmd(3'h7, FRP_OP_PB_PROG, BASE | (i << 14), 0, 0, 0);
      cmd(3'h7, FRP_OP_PB_ERASE, BASE | 32'h4000, 0, 0, 0);
      chk("bits", block_protect_bits, 4'h4);
      cmd(3'h7, FRP_OP_PB_ERASE, BASE | 32'h8000, 0, 0, 0);
      chk("bits", block_protect_bits, 0);
      report_and_stop;
   end
endmodule : tb_top
